// [hdl/imz_carrier.sv]
// Carrier coefficient table: sine and quadrature cosine terms for one phase step.
// Assumes the phase index counts accepted input samples modulo eight.
`timescale 1ns/1ps
module imz_carrier (
	input  wire logic [1:0]               mod_sel_in,
	input  wire logic [2:0]               phase_in,
	output imz_pkg::imz_carrier_type      carrier_out
);

	// ****************************************
	// Lookup
	// ****************************************
	function automatic logic signed [17:0] coef_at(input logic [1:0] sel, input logic [2:0] idx);
		logic signed [17:0] c;
		c = imz_pkg::COEF_ONE;
		case (sel)
			imz_pkg::MOD_HALF: begin
				c = idx[0] ? -imz_pkg::COEF_ONE : imz_pkg::COEF_ONE;
			end
			imz_pkg::MOD_QUARTER: begin
				case (idx[1:0])
					2'h1:    c = imz_pkg::COEF_ONE;
					2'h3:    c = -imz_pkg::COEF_ONE;
					default: c = imz_pkg::COEF_ZERO;
				endcase
			end
			imz_pkg::MOD_EIGHTH: begin
				// Last step kept positive exactly as specified
				case (idx)
					3'h1:    c = imz_pkg::COEF_P707;
					3'h2:    c = imz_pkg::COEF_ONE;
					3'h3:    c = imz_pkg::COEF_P707;
					3'h5:    c = -imz_pkg::COEF_P707;
					3'h6:    c = -imz_pkg::COEF_ONE;
					3'h7:    c = imz_pkg::COEF_P707;
					default: c = imz_pkg::COEF_ZERO;
				endcase
			end
			default: c = imz_pkg::COEF_ONE;
		endcase
		return c;
	endfunction

	logic [2:0] cos_idx;

	// Quarter-period lead gives the cosine term in the quarter and eighth modes; other modes use no lead
	always_comb begin
		case (mod_sel_in)
			imz_pkg::MOD_EIGHTH:  cos_idx = phase_in + 3'h2;
			imz_pkg::MOD_QUARTER: cos_idx = phase_in + 3'h1;
			default:              cos_idx = phase_in;
		endcase
	end

	assign carrier_out.sin_c = coef_at(mod_sel_in, phase_in);
	assign carrier_out.cos_c = coef_at(mod_sel_in, cos_idx);

endmodule

// [hdl/imz_modulator.sv]
// Digital modulator and midscale insertion ahead of the DAC core, with APB control.
// Assumes filter chain, APB master and DAC core all run on core_clk_in.
`timescale 1ns/1ps
module imz_modulator (
	input  wire logic                       core_clk_in,
	input  wire logic                       resetn_in,
	input  wire logic [imz_pkg::ADDR_W-1:0] paddr_in,
	input  wire logic                       psel_in,
	input  wire logic                       penable_in,
	input  wire logic                       pwrite_in,
	input  wire logic [31:0]                pwdata_in,
	input  wire logic [3:0]                 pstrb_in,
	output logic      [31:0]                prdata_out,
	output logic                            pready_out,
	output logic                            pslverr_out,
	input  wire logic                       in_valid_in,
	input  imz_pkg::imz_iq_type             in_data_in,
	output logic                            in_ready_out,
	output logic                            out_valid_out,
	output imz_pkg::imz_iq_type             out_data_out,
	output logic      [3:0]                 interp_factor_out,
	output logic                            rate_double_out
);

	// ****************************************
	// Declarations
	// ****************************************
	typedef enum logic [1:0] {
		SLOT_SAMPLE = 2'b01,
		SLOT_MID    = 2'b10
	} imz_slot_type;

	imz_slot_type              slot;
	imz_slot_type              next_slot;
	logic [7:0]                ctrl;
	logic [2:0]                phase;
	logic                      ctrl_wr;
	logic                      cfg_change;
	logic                      take;
	logic [1:0]                mod_sel;
	logic                      stuff_en;
	logic                      cplx_act;
	imz_pkg::imz_carrier_type  carrier;
	logic [15:0]               lane_raw  [2];
	logic signed [34:0]        lane_ext  [2];
	logic signed [34:0]        prod_sin  [2];
	logic signed [34:0]        prod_cos  [2];
	logic signed [34:0]        lane_sum  [2];
	logic [15:0]               lane_code [2];
	logic [31:0]               next_prdata;
	logic signed [34:0]        sin_ext;
	logic signed [34:0]        cos_ext;
	logic signed [34:0]        sum_i;
	logic signed [34:0]        sum_q;
	imz_pkg::imz_iq_type       next_out;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic addr_mapped(input logic [imz_pkg::ADDR_W-1:0] a);
		return (a == imz_pkg::CTRL_ADDR) || (a == imz_pkg::STATUS_ADDR);
	endfunction

	function automatic logic addr_is_ctrl(input logic [imz_pkg::ADDR_W-1:0] a);
		return a == imz_pkg::CTRL_ADDR;
	endfunction

	function automatic logic in_mid_slot(input imz_slot_type s);
		return s == SLOT_MID;
	endfunction

	// Status word lets software watch the carrier phase and the live mode
	function automatic logic [31:0] status_word(input logic [2:0] ph,
	                                             input logic       mid,
	                                             input logic       cplx,
	                                             input logic [3:0] factor);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[imz_pkg::STAT_PHASE_LSB +: 3] = ph;
		w[imz_pkg::STAT_SLOT_BIT]       = mid;
		w[imz_pkg::STAT_CPLX_BIT]       = cplx;
		w[imz_pkg::STAT_RATE_LSB +: 4]  = factor;
		return w;
	endfunction

	// Rescale, saturate and convert to offset binary for the DAC core
	function automatic logic [15:0] to_dac(input logic signed [34:0] v);
		logic signed [18:0] t;
		logic [15:0]        s;
		t = v[34:16];
		if (t > 19'sh0_7FFF) begin
			s = 16'h7FFF;
		end else if (t < -19'sh0_8000) begin
			s = 16'h8000;
		end else begin
			s = t[15:0];
		end
		return {~s[15], s[14:0]};
	endfunction

	function automatic logic [3:0] rate_factor(input logic [1:0] r);
		logic [3:0] f;
		case (r)
			imz_pkg::RATE_2X: f = 4'h2;
			imz_pkg::RATE_4X: f = 4'h4;
			imz_pkg::RATE_8X: f = 4'h8;
			default:          f = 4'h1;
		endcase
		return f;
	endfunction

	// ****************************************
	// APB slave
	// ****************************************
	// Zero wait states: read data is captured in the setup cycle
	assign pready_out  = 1'b1;
	assign pslverr_out = psel_in & penable_in & ~addr_mapped(paddr_in);
	assign ctrl_wr     = psel_in & penable_in & pwrite_in & pstrb_in[0]
	                     & addr_is_ctrl(paddr_in);
	assign cfg_change  = ctrl_wr
	                     & (pwdata_in[7:imz_pkg::PLUS_BIT] != ctrl[7:imz_pkg::PLUS_BIT]);

	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ctrl <= imz_pkg::CTRL_RESET;
		end else if (ctrl_wr) begin
			ctrl <= pwdata_in[7:0];
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	always_comb begin
		if (addr_is_ctrl(paddr_in)) begin
			next_prdata = {24'h00_0000, ctrl};
		end else if (paddr_in == imz_pkg::STATUS_ADDR) begin
			next_prdata = status_word(phase, in_mid_slot(slot), cplx_act, interp_factor_out);
		end else begin
			next_prdata = 32'h0000_0000;
		end
	end

	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			prdata_out <= 32'h0000_0000;
		end else if (psel_in && !penable_in) begin
			prdata_out <= next_prdata;
		end
	end

	// ****************************************
	// Mode decode
	// ****************************************
	assign mod_sel  = ctrl[imz_pkg::MOD_LSB +: 2];
	assign stuff_en = ctrl[imz_pkg::STUFF_BIT];
	// No quadrature pair exists at half rate, so real mixing is kept there
	assign cplx_act = ctrl[imz_pkg::CPLX_BIT]
	                  & ((mod_sel == imz_pkg::MOD_QUARTER)
	                  | (mod_sel == imz_pkg::MOD_EIGHTH));

	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			interp_factor_out <= 4'h1;
		end else begin
			interp_factor_out <= rate_factor(ctrl[imz_pkg::RATE_LSB +: 2]);
		end
	end

	// Registered so the rate change reaches the core on a clean boundary
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rate_double_out <= 1'b0;
		end else begin
			rate_double_out <= stuff_en;
		end
	end

	// ****************************************
	// Carrier phase
	// ****************************************
	assign take = in_valid_in & in_ready_out;

	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			phase <= imz_pkg::PHASE_RESET;
		end else if (cfg_change) begin
			phase <= imz_pkg::PHASE_RESET;
		end else if (take) begin
			phase <= phase + 3'h1;
		end
	end

	imz_carrier u_carrier (
		.mod_sel_in  (mod_sel),
		.phase_in    (phase),
		.carrier_out (carrier)
	);

	// ****************************************
	// Modulator arithmetic
	// ****************************************
	assign lane_raw[0] = in_data_in.i;
	assign lane_raw[1] = in_data_in.q;
	assign cos_ext     = {{17{carrier.cos_c[17]}}, carrier.cos_c};

	// Sign of the sine term picks the positive or negative exponential
	always_comb begin
		sin_ext = {{17{carrier.sin_c[17]}}, carrier.sin_c};
		if (cplx_act && !ctrl[imz_pkg::PLUS_BIT]) begin
			sin_ext = -sin_ext;
		end
	end

	// Four shared products serve both the real and the complex mixer
	for (genvar g = 0; g < 2; g++) begin : g_mix
		assign lane_ext[g] = {{19{lane_raw[g][15]}}, lane_raw[g]};
		assign prod_sin[g] = lane_ext[g] * sin_ext;
		assign prod_cos[g] = lane_ext[g] * cos_ext;
	end

	always_comb begin
		if (cplx_act) begin
			sum_i = prod_cos[0] - prod_sin[1];
			sum_q = prod_sin[0] + prod_cos[1];
		end else begin
			sum_i = prod_sin[0];
			sum_q = prod_sin[1];
		end
	end

	// ****************************************
	// Output coding
	// ****************************************
	assign lane_sum[0] = sum_i;
	assign lane_sum[1] = sum_q;

	// Each lane saturates on its own, so one overrange never disturbs the other
	for (genvar g = 0; g < 2; g++) begin : g_code
		assign lane_code[g] = to_dac(lane_sum[g]);
	end

	assign next_out.i = lane_code[0];
	assign next_out.q = lane_code[1];

	// ****************************************
	// Midscale insertion
	// ****************************************
	// No buffering: the filter chain is stalled in every midscale slot
	assign in_ready_out = (slot == SLOT_SAMPLE);

	always_comb begin
		case (slot)
			SLOT_SAMPLE: next_slot = (take && stuff_en) ? SLOT_MID : SLOT_SAMPLE;
			SLOT_MID:    next_slot = SLOT_SAMPLE;
			default:     next_slot = SLOT_SAMPLE;
		endcase
	end

	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			slot <= SLOT_SAMPLE;
		end else begin
			slot <= next_slot;
		end
	end

	// ****************************************
	// Output register
	// ****************************************
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			out_valid_out <= 1'b0;
			out_data_out  <= {imz_pkg::MIDSCALE, imz_pkg::MIDSCALE};
		end else if (in_mid_slot(slot)) begin
			out_valid_out <= 1'b1;
			out_data_out  <= {imz_pkg::MIDSCALE, imz_pkg::MIDSCALE};
		end else if (take) begin
			out_valid_out <= 1'b1;
			out_data_out  <= next_out;
		end else begin
			out_valid_out <= 1'b0;
		end
	end

endmodule

// [hdl/imz_pkg.sv]
// Shared constants and types of the modulator and midscale-insertion back end.
// Assumes one DAC-rate clock for the stream and the APB register port.
package imz_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam int          ADDR_W       = 12;
	localparam logic [11:0] CTRL_INDEX   = 12'h001;
	localparam logic [11:0] STATUS_INDEX = 12'h002;
	localparam logic [11:0] CTRL_ADDR    = {CTRL_INDEX[9:0], 2'b00};
	localparam logic [11:0] STATUS_ADDR  = {STATUS_INDEX[9:0], 2'b00};
	localparam logic [7:0]  CTRL_RESET   = 8'h00;

	// ****************************************
	// Control fields
	// ****************************************
	localparam int RATE_LSB  = 6;
	localparam int MOD_LSB   = 4;
	localparam int STUFF_BIT = 3;
	localparam int CPLX_BIT  = 2;
	localparam int PLUS_BIT  = 1;

	localparam logic [1:0] RATE_1X = 2'b00;
	localparam logic [1:0] RATE_2X = 2'b01;
	localparam logic [1:0] RATE_4X = 2'b10;
	localparam logic [1:0] RATE_8X = 2'b11;

	localparam logic [1:0] MOD_OFF     = 2'b00;
	localparam logic [1:0] MOD_HALF    = 2'b01;
	localparam logic [1:0] MOD_QUARTER = 2'b10;
	localparam logic [1:0] MOD_EIGHTH  = 2'b11;

	// ****************************************
	// Status fields
	// ****************************************
	localparam int STAT_PHASE_LSB = 0;
	localparam int STAT_SLOT_BIT  = 3;
	localparam int STAT_CPLX_BIT  = 4;
	localparam int STAT_RATE_LSB  = 8;

	// ****************************************
	// Arithmetic
	// ****************************************
	localparam int                 COEF_W    = 18;
	localparam int                 COEF_FRAC = 16;
	localparam logic signed [17:0] COEF_ZERO = 18'sh0_0000;
	localparam logic signed [17:0] COEF_ONE  = 18'sh1_0000;
	localparam logic signed [17:0] COEF_P707 = 18'sh0_B4FE;
	localparam logic [15:0]        MIDSCALE  = 16'h8000;
	localparam logic [2:0]         PHASE_RESET = 3'h0;

	typedef struct packed {
		logic signed [17:0] sin_c;
		logic signed [17:0] cos_c;
	} imz_carrier_type;

	typedef struct packed {
		logic [15:0] i;
		logic [15:0] q;
	} imz_iq_type;

endpackage

// [tb/imz_chain_model.sv]
// Filter chain source and DAC core sink around the modulator.
// Assumes the bench fills src off the clock edge and reads got.
`timescale 1ns/1ps
module imz_chain_model (
	input  wire logic          core_clk_in,
	input  wire logic          in_ready_in,
	input  wire logic          out_valid_in,
	input  imz_pkg::imz_iq_type out_data_in,
	output logic               in_valid_out,
	output imz_pkg::imz_iq_type in_data_out
);
	imz_pkg::imz_iq_type src[$];
	imz_pkg::imz_iq_type got[$];
	initial begin
		in_valid_out = 1'b0;
		in_data_out = 32'h0000_0000;
	end
	// ****
	// Source holds a sample through the midscale slot
	// ****
	always @(posedge core_clk_in) begin
		if (in_valid_out && in_ready_in)
			void'(src.pop_front());
		in_valid_out <= src.size() > 0;
		// Idle data toggles so a stale sample is never mistaken for a live one
		in_data_out <= (src.size() > 0) ? src[0] : ~in_data_out;
		if (out_valid_in)
			got.push_back(out_data_in);
	end
endmodule

// [tb/imz_modulator_assertions.sv]
// Port-level checks of the modulator and midscale insertion.
// Assumes one clock and an async low reset; bound to imz_modulator.
`timescale 1ns/1ps
module imz_modulator_assertions (
	input  wire logic [imz_pkg::ADDR_W-1:0] paddr_in,
	input  wire logic                       core_clk_in,
	input  wire logic                       resetn_in,
	input  wire logic                       psel_in,
	input  wire logic                       penable_in,
	input  wire logic                       pwrite_in,
	input  wire logic [31:0]                pwdata_in,
	input  wire logic [3:0]                 pstrb_in,
	input  wire logic                       pready_out,
	input  wire logic                       in_valid_in,
	input  imz_pkg::imz_iq_type             in_data_in,
	input  wire logic                       in_ready_out,
	input  wire logic                       out_valid_out,
	input  imz_pkg::imz_iq_type             out_data_out,
	input  wire logic [3:0]                 interp_factor_out,
	input  wire logic                       rate_double_out
);
	// ****
	// Control shadow and phase
	// ****
	logic [7:0] ctl;
	logic [2:0] ph;
	wire        wr = psel_in && penable_in && pready_out && pwrite_in && pstrb_in[0]
		&& paddr_in == imz_pkg::CTRL_ADDR;
	wire        take = in_valid_in && in_ready_out;
	wire        mid = out_data_out == {imz_pkg::MIDSCALE, imz_pkg::MIDSCALE};
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in)
			ctl <= 8'h00;
		else if (wr)
			ctl <= pwdata_in[7:0];
	end
	// Reset beats increment, as the sample of a write cycle uses old phase
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in)
			ph <= 3'h0;
		else if (wr && pwdata_in[7:1] != ctl[7:1])
			ph <= 3'h0;
		else if (take)
			ph <= ph + 3'h1;
	end
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!resetn_in);
	// ****
	// Properties
	// ****
	AST_RATE8: assert property (wr && pwdata_in[7:6] == 2'b11 |=> ##1 interp_factor_out == 4'h8)
		else $error("factor not 8");
	AST_STUFF_ON: assert property (wr && pwdata_in[3] |=> ##1 rate_double_out)
		else $error("insertion not on");
	AST_STUFF_OFF: assert property (wr && !pwdata_in[3] |=> ##1 !rate_double_out)
		else $error("insertion not off");
	AST_SLOT: assert property (take && ctl[3] |=> !in_ready_out && out_valid_out ##1 out_valid_out && mid)
		else $error("midscale slot wrong");
	AST_ANSWER: assert property (take |=> out_valid_out)
		else $error("no output after take");
	AST_HALF: assert property (take && ctl[5:4] == imz_pkg::MOD_HALF && !ph[0] |=> out_data_out.i == ($past(in_data_in.i) ^ 16'h8000))
		else $error("half rate step wrong");
	AST_QZERO: assert property (take && ctl[5:4] == imz_pkg::MOD_QUARTER && !ctl[2] && !ph[0] |=> mid)
		else $error("quarter zero step wrong");
	AST_EPEAK: assert property (take && ctl[5:4] == imz_pkg::MOD_EIGHTH && !ctl[2] && ph == 3'h2 |=> out_data_out.q == ($past(in_data_in.q) ^ 16'h8000))
		else $error("eighth peak step wrong");
	AST_CPLX: assert property (take && ctl[5:4] == imz_pkg::MOD_QUARTER && ctl[2:1] == 2'b11 && ph == 3'h1 |=> out_data_out.q == ($past(in_data_in.i) ^ 16'h8000))
		else $error("complex step wrong");
	AST_OFF: assert property (take && ctl[5:4] == imz_pkg::MOD_OFF |=> out_data_out == ($past(in_data_in) ^ 32'h8000_8000))
		else $error("unmodulated path wrong");
	COV_STUFF: cover property (take && rate_double_out);
	COV_CPLX: cover property (take && ctl[2] && ctl[5:4] == imz_pkg::MOD_QUARTER);
	COV_BACK: cover property (take ##1 take);
endmodule

bind imz_modulator imz_modulator_assertions u_chk (.paddr_in, .core_clk_in, .resetn_in,
	.psel_in, .penable_in, .pwrite_in, .pwdata_in, .pstrb_in, .pready_out, .in_valid_in,
	.in_data_in, .in_ready_out, .out_valid_out, .out_data_out, .interp_factor_out,
	.rate_double_out);

// [tb/tb_imz_modulator.sv]
// Self-checking bench of the modulator with APB control.
// Assumes the design package compiled first.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
	$display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_imz_modulator;
	localparam int U = 65536;
	localparam int H = 46334;
	int tab [4][8] = '{'{U, U, U, U, U, U, U, U}, '{U, -U, U, -U, U, -U, U, -U},
		'{0, U, 0, -U, 0, U, 0, -U}, '{0, H, U, H, 0, -H, -U, H}};
	logic core_clk_in, resetn_in, psel, penable, pwrite, pready, pslverr, er;
	logic in_valid, in_ready, out_valid, rate_double;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] ifac;
	imz_pkg::imz_iq_type in_data, out_data;
	int n_errors, checks;
	imz_modulator dut (.core_clk_in, .resetn_in, .paddr_in(paddr), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata), .pstrb_in(4'hf),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
		.in_valid_in(in_valid), .in_data_in(in_data), .in_ready_out(in_ready),
		.out_valid_out(out_valid), .out_data_out(out_data), .interp_factor_out(ifac),
		.rate_double_out(rate_double));
	imz_chain_model m (.core_clk_in, .in_ready_in(in_ready), .out_valid_in(out_valid),
		.out_data_in(out_data), .in_valid_out(in_valid), .in_data_out(in_data));
	// ****
	// Bus, model and report
	// ****
	task automatic final_report;
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk_in);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk_in);
		penable <= 1'b1;
		do begin
			@(posedge core_clk_in);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			n_errors++;
			final_report();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic imz_pkg::imz_iq_type expv(logic [7:0] c, int p, imz_pkg::imz_iq_type s);
		int sv, cv, i, q;
		imz_pkg::imz_iq_type r;
		sv = tab[c[5:4]][p % 8];
		cv = tab[c[5:4]][(p + (c[4] ? 2 : 1)) % 8];
		if (c[2] && c[5]) begin
			sv = c[1] ? sv : -sv;
			i = int'($signed(s.i)) * cv - int'($signed(s.q)) * sv;
			q = int'($signed(s.i)) * sv + int'($signed(s.q)) * cv;
		end else begin
			i = int'($signed(s.i)) * sv;
			q = int'($signed(s.q)) * sv;
		end
		r.i = 16'(i >>> 16) ^ 16'h8000;
		r.q = 16'(q >>> 16) ^ 16'h8000;
		return r;
	endfunction
	// Double write forces a settings change, so the phase always restarts
	task automatic run(input logic [7:0] c, input int n);
		int k, w;
		imz_pkg::imz_iq_type s[$];
		imz_pkg::imz_iq_type e;
		apb(1'b1, imz_pkg::CTRL_ADDR, {24'h0, c ^ 8'h02});
		apb(1'b1, imz_pkg::CTRL_ADDR, {24'h0, c});
		m.got.delete();
		@(negedge core_clk_in);
		for (k = 0; k < n; k++) begin
			e.i = 16'(k * 1100 - 3000);
			e.q = 16'(2000 - k * 900);
			s.push_back(e);
			m.src.push_back(e);
		end
		w = c[3] ? 2 * n : n;
		for (k = 0; k < 200 && m.got.size() < w; k++)
			@(posedge core_clk_in);
		if (m.got.size() < w) begin
			n_errors++;
			final_report();
		end
		for (k = 0; k < n; k++) begin
			`CHK("sample", expv(c, k, s[k]), m.got[c[3] ? 2 * k : k])
			if (c[3])
				`CHK("midscale", 32'h8000_8000, m.got[2 * k + 1])
		end
	endtask
	// ****
	// Scenarios
	// ****
	task automatic t_rate;
		for (int r = 0; r < 4; r++) begin
			apb(1'b1, imz_pkg::CTRL_ADDR, {24'h0, 2'(r), 6'h0});
			repeat (2) @(negedge core_clk_in);
			`CHK("factor", 4'(1 << r), ifac)
			apb(1'b0, imz_pkg::CTRL_ADDR, 32'h0);
			`CHK("ctrl", {24'h0, 2'(r), 6'h0}, rd)
		end
	endtask
	task automatic t_mods;
		for (int md = 0; md < 4; md++)
			run({2'b11, 2'(md), 4'h0}, 9);
	endtask
	task automatic t_cplx;
		run(8'hA6, 5);
		run(8'hA4, 5);
		run(8'h94, 4);
		run(8'hB6, 8);
	endtask
	task automatic t_stuff;
		run(8'hF8, 5);
		`CHK("double", 1'b1, rate_double)
		run(8'hF0, 3);
		`CHK("double", 1'b0, rate_double)
	endtask
	task automatic t_err;
		apb(1'b1, 12'h010, 32'h0000_00ff);
		apb(1'b0, 12'h010, 32'h0);
		`CHK("slverr", 1'b1, er)
		apb(1'b0, imz_pkg::CTRL_ADDR, 32'h0);
		`CHK("ctrl", 32'h0000_00f0, rd)
		apb(1'b0, imz_pkg::STATUS_ADDR, 32'h0);
		`CHK("status", 32'h0000_0803, rd)
	endtask
	initial begin
		core_clk_in = 1'b0;
		forever #50 core_clk_in = ~core_clk_in;
	end
	initial begin
		{resetn_in, psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (8) @(posedge core_clk_in);
		resetn_in <= 1'b1;
		@(negedge core_clk_in);
		`CHK("factor", 4'h1, ifac)
		t_rate();
		t_mods();
		t_cplx();
		t_stuff();
		t_err();
		final_report();
	end
endmodule
